// File: verilog/omsc_top.sv
// Sideband control of a pluggable optical module: select, reset, low power, presence, interrupt, two-wire slave
// Function
// - Answer two-wire traffic only while selected
// - Two-wire link reads and writes memory map
// - Long reset pulse restores all defaults
// - Reset done raises interrupt, clears not-ready
// - Power-up posts reset-done interrupt unprompted
// - Low-power select limits module power
// - Inserted module grounds presence line
// - Interrupt driven low on fault or status
// - Interrupt is open collector, host pull-up
// - Seven sideband pins provided
// - Pin directions: inputs, outputs, two two-way
`default_nettype none

module omsc_top (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Sideband inputs from host
  input  wire logic module_select_n,
  input  wire logic module_reset_n,
  input  wire logic low_power_select,
  // Two-wire clock pin
  input  wire logic scl_in,
  output logic      scl_out,
  output logic      scl_oe_n,
  // Two-wire data pin
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  // Presence and interrupt pins
  output logic      module_present_n,
  output logic      module_present_oe_n,
  output logic      interrupt_n,
  output logic      interrupt_oe_n,
  // Module internals
  input  wire logic fault_event,
  output logic      high_power_enable,
  output logic      data_not_ready
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [omsc_pkg::SYNC_W-1:0] sync1_reg;
  logic [omsc_pkg::SYNC_W-1:0] sync2_reg;
  logic                        scl_d_reg;
  logic                        sda_d_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= omsc_pkg::SYNC_IDLE;
      sync2_reg <= omsc_pkg::SYNC_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {low_power_select, module_reset_n, module_select_n, sda_in, scl_in};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[omsc_pkg::SYNC_SCL];
      sda_d_reg <= sync2_reg[omsc_pkg::SYNC_SDA];
    end
  end

  wire scl_s      = sync2_reg[omsc_pkg::SYNC_SCL];
  wire sda_s      = sync2_reg[omsc_pkg::SYNC_SDA];
  wire sel_n_s    = sync2_reg[omsc_pkg::SYNC_SEL];
  wire rst_s      = sync2_reg[omsc_pkg::SYNC_RST];
  wire low_pwr_s  = sync2_reg[omsc_pkg::SYNC_LP];
  wire scl_rise   = scl_s & ~scl_d_reg;
  wire scl_fall   = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // Reset qualification and module mode
  // ----------------------------------------------------------------
  omsc_pkg::omsc_mode_t              mode_reg;
  omsc_pkg::omsc_mode_t              mode_next;
  logic [omsc_pkg::RCNT_W-1:0]       rst_cnt_reg;
  logic [omsc_pkg::ADDR_W-1:0]       init_addr_reg;
  logic [omsc_pkg::FLAG_W-1:0]       flags_reg;
  logic [omsc_pkg::FLAG_W-1:0]       flags_next;
  logic                              int_drive_reg;
  logic                              high_power_reg;
  logic                              flag_clear;

  // Counter saturates, so a pin held low for hours never wraps into a short pulse
  wire qualified  = ~rst_s && (rst_cnt_reg == omsc_pkg::RESET_MIN_CNT);
  wire init_last  = (init_addr_reg == omsc_pkg::ADDR_LAST);
  wire mode_ready = (mode_reg == omsc_pkg::OMSC_READY);
  wire set_done   = (mode_reg == omsc_pkg::OMSC_INIT) && init_last && ~qualified;
  wire set_fault  = fault_event & mode_ready;

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      omsc_pkg::OMSC_INIT: begin
        if (qualified) begin
          mode_next = omsc_pkg::OMSC_HOLD;
        end else if (init_last) begin
          mode_next = omsc_pkg::OMSC_READY;
        end
      end
      omsc_pkg::OMSC_READY: begin
        if (qualified) begin
          mode_next = omsc_pkg::OMSC_HOLD;
        end
      end
      omsc_pkg::OMSC_HOLD: begin
        if (rst_s) begin
          mode_next = omsc_pkg::OMSC_INIT;
        end
      end
      default: mode_next = omsc_pkg::OMSC_INIT;
    endcase
  end

  // Set wins over clear-on-read; a complete reset wipes both flags
  always_comb begin
    flags_next = mode_ready ? (flags_reg & ~{omsc_pkg::FLAG_W{flag_clear}}) : omsc_pkg::FLAGS_CLEAR;
    flags_next[omsc_pkg::FLAG_DONE_BIT]  = flags_next[omsc_pkg::FLAG_DONE_BIT] | set_done;
    flags_next[omsc_pkg::FLAG_FAULT_BIT] = flags_next[omsc_pkg::FLAG_FAULT_BIT] | set_fault;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg       <= omsc_pkg::OMSC_INIT;
      rst_cnt_reg    <= omsc_pkg::RCNT_ZERO;
      init_addr_reg  <= omsc_pkg::ADDR_ZERO;
      flags_reg      <= omsc_pkg::FLAGS_CLEAR;
      int_drive_reg  <= 1'b0;
      high_power_reg <= 1'b0;
    end else begin
      mode_reg       <= mode_next;
      rst_cnt_reg    <= rst_s ? omsc_pkg::RCNT_ZERO :
                        (qualified ? rst_cnt_reg : rst_cnt_reg + omsc_pkg::RCNT_ONE);
      init_addr_reg  <= (mode_reg == omsc_pkg::OMSC_INIT) ? init_addr_reg + omsc_pkg::ADDR_ONE : omsc_pkg::ADDR_ZERO;
      flags_reg      <= flags_next;
      int_drive_reg  <= |flags_reg;
      high_power_reg <= ~low_pwr_s & mode_ready;
    end
  end

  // ----------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------
  omsc_pkg::omsc_link_t          link_reg;
  omsc_pkg::omsc_link_t          link_next;
  logic [3:0]                    bit_cnt_reg;
  logic [3:0]                    bit_cnt_next;
  logic [omsc_pkg::DATA_W-1:0]   shift_reg;
  logic [omsc_pkg::DATA_W-1:0]   shift_next;
  logic [omsc_pkg::ADDR_W-1:0]   ptr_reg;
  logic [omsc_pkg::ADDR_W-1:0]   ptr_next;
  logic                          rw_reg;
  logic                          rw_next;
  logic                          sda_drive_reg;
  logic                          sda_drive_next;
  logic                          do_load;
  logic                          link_we;
  logic [omsc_pkg::DATA_W-1:0]   mem_rdata;

  wire link_enable = ~sel_n_s & mode_ready;
  wire byte_done   = (bit_cnt_reg == omsc_pkg::BITS_PER_BYTE);
  wire addr_match  = (shift_reg[omsc_pkg::DATA_W-1:1] == omsc_pkg::DEV_ADDR);
  wire [omsc_pkg::DATA_W-1:0] status_byte = {{(omsc_pkg::DATA_W-1){1'b0}}, ~mode_ready};
  wire [omsc_pkg::DATA_W-1:0] flag_byte   = {{(omsc_pkg::DATA_W-omsc_pkg::FLAG_W){1'b0}}, flags_reg};
  wire [omsc_pkg::DATA_W-1:0] rd_byte     = (ptr_reg == omsc_pkg::STATUS_ADDR) ? status_byte :
                                            (ptr_reg == omsc_pkg::FLAG_ADDR) ? flag_byte : mem_rdata;

  always_comb begin
    link_next      = link_reg;
    bit_cnt_next   = bit_cnt_reg;
    shift_next     = shift_reg;
    ptr_next       = ptr_reg;
    rw_next        = rw_reg;
    sda_drive_next = sda_drive_reg;
    do_load        = 1'b0;
    link_we        = 1'b0;
    flag_clear     = 1'b0;
    if (!link_enable) begin
      link_next      = omsc_pkg::OMSC_L_IDLE;
      sda_drive_next = 1'b0;
      if (!mode_ready) begin
        ptr_next = omsc_pkg::ADDR_ZERO;
      end
    end else if (start_cond) begin
      link_next      = omsc_pkg::OMSC_L_ADDR;
      bit_cnt_next   = omsc_pkg::BIT_ZERO;
      sda_drive_next = 1'b0;
    end else if (stop_cond) begin
      link_next      = omsc_pkg::OMSC_L_IDLE;
      sda_drive_next = 1'b0;
    end else begin
      unique case (link_reg)
        omsc_pkg::OMSC_L_IDLE: begin
        end
        omsc_pkg::OMSC_L_ADDR, omsc_pkg::OMSC_L_PTR, omsc_pkg::OMSC_L_WDATA: begin
          if (scl_rise && !byte_done) begin
            shift_next   = {shift_reg[omsc_pkg::DATA_W-2:0], sda_s};
            bit_cnt_next = bit_cnt_reg + omsc_pkg::BIT_ONE;
          end else if (scl_fall && byte_done) begin
            bit_cnt_next   = omsc_pkg::BIT_ZERO;
            sda_drive_next = 1'b1;
            if (link_reg == omsc_pkg::OMSC_L_ADDR) begin
              rw_next        = shift_reg[0];
              sda_drive_next = addr_match;
              link_next      = addr_match ? omsc_pkg::OMSC_L_ADDR_ACK : omsc_pkg::OMSC_L_IDLE;
            end else if (link_reg == omsc_pkg::OMSC_L_PTR) begin
              ptr_next  = shift_reg;
              link_next = omsc_pkg::OMSC_L_PTR_ACK;
            end else begin
              link_we   = ~omsc_pkg::omsc_is_live(ptr_reg);
              ptr_next  = ptr_reg + omsc_pkg::ADDR_ONE;
              link_next = omsc_pkg::OMSC_L_WDATA_ACK;
            end
          end
        end
        omsc_pkg::OMSC_L_ADDR_ACK: begin
          if (scl_fall) begin
            do_load        = rw_reg;
            sda_drive_next = 1'b0;
            link_next      = rw_reg ? omsc_pkg::OMSC_L_RDATA : omsc_pkg::OMSC_L_PTR;
          end
        end
        omsc_pkg::OMSC_L_PTR_ACK, omsc_pkg::OMSC_L_WDATA_ACK: begin
          if (scl_fall) begin
            sda_drive_next = 1'b0;
            link_next      = omsc_pkg::OMSC_L_WDATA;
          end
        end
        omsc_pkg::OMSC_L_RDATA: begin
          if (scl_fall && byte_done) begin
            sda_drive_next = 1'b0;
            link_next      = omsc_pkg::OMSC_L_RDATA_ACK;
          end else if (scl_fall) begin
            sda_drive_next = ~shift_reg[omsc_pkg::DATA_W-2];
            shift_next     = {shift_reg[omsc_pkg::DATA_W-2:0], 1'b0};
            bit_cnt_next   = bit_cnt_reg + omsc_pkg::BIT_ONE;
          end
        end
        omsc_pkg::OMSC_L_RDATA_ACK: begin
          if (scl_rise) begin
            shift_next = {shift_reg[omsc_pkg::DATA_W-2:0], sda_s};
          end else if (scl_fall) begin
            do_load   = ~shift_reg[0];
            link_next = shift_reg[0] ? omsc_pkg::OMSC_L_IDLE : omsc_pkg::OMSC_L_RDATA;
          end
        end
        default: link_next = omsc_pkg::OMSC_L_IDLE;
      endcase
    end
    if (do_load) begin
      shift_next     = rd_byte;
      sda_drive_next = ~rd_byte[omsc_pkg::DATA_W-1];
      ptr_next       = ptr_reg + omsc_pkg::ADDR_ONE;
      bit_cnt_next   = omsc_pkg::BIT_ONE;
      flag_clear     = (ptr_reg == omsc_pkg::FLAG_ADDR);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link_reg      <= omsc_pkg::OMSC_L_IDLE;
      bit_cnt_reg   <= omsc_pkg::BIT_ZERO;
      shift_reg     <= omsc_pkg::MEM_DEFAULT;
      ptr_reg       <= omsc_pkg::ADDR_ZERO;
      rw_reg        <= 1'b0;
      sda_drive_reg <= 1'b0;
    end else begin
      link_reg      <= link_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_reg     <= shift_next;
      ptr_reg       <= ptr_next;
      rw_reg        <= rw_next;
      sda_drive_reg <= sda_drive_next;
    end
  end

  // ----------------------------------------------------------------
  // Memory and pins
  // ----------------------------------------------------------------
  wire                        in_init  = (mode_reg == omsc_pkg::OMSC_INIT);
  wire                        mem_we   = in_init | link_we;
  wire [omsc_pkg::ADDR_W-1:0] mem_wa   = in_init ? init_addr_reg : ptr_reg;
  wire [omsc_pkg::DATA_W-1:0] mem_wd   = in_init ? omsc_pkg::MEM_DEFAULT : shift_reg;

  omsc_mem u_mem (
    .clk   (clk),
    .reset (reset),
    .we    (mem_we),
    .waddr (mem_wa),
    .wdata (mem_wd),
    .raddr (ptr_reg),
    .rdata (mem_rdata)
  );

  // Open-drain pins only ever pull low; the host's pull-ups make the high level
  assign scl_out             = 1'b0;
  assign scl_oe_n            = 1'b1;
  assign sda_out             = 1'b0;
  assign sda_oe_n            = ~sda_drive_reg;
  assign module_present_n    = 1'b0;
  assign module_present_oe_n = 1'b0;
  assign interrupt_n         = 1'b0;
  assign interrupt_oe_n      = ~int_drive_reg;
  assign high_power_enable   = high_power_reg;
  assign data_not_ready      = ~mode_ready;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seq_sweep_end;
    set_done;
  endsequence

  sequence seq_done_posted;
    (!data_not_ready && flags_reg[omsc_pkg::FLAG_DONE_BIT]) ##1 !interrupt_oe_n;
  endsequence

  AST_DESELECT_QUIET: assert property (sel_n_s |=> (link_reg == omsc_pkg::OMSC_L_IDLE) && sda_oe_n)
    else $error("Slave active while deselected");
  AST_BAD_ADDR_NAK: assert property ((link_reg == omsc_pkg::OMSC_L_ADDR) && link_enable && !start_cond
    && !stop_cond && scl_fall && byte_done && !addr_match |=> sda_oe_n && (link_reg == omsc_pkg::OMSC_L_IDLE))
    else $error("Foreign address acknowledged");
  AST_LONG_RESET: assert property (qualified |=> (mode_reg == omsc_pkg::OMSC_HOLD) ##1 data_not_ready)
    else $error("Qualified reset not taken");
  AST_DONE_POSTED: assert property (seq_sweep_end |=> seq_done_posted)
    else $error("Reset completion not posted");
  AST_POWER_UP: assert property ($fell(reset) |-> ##[1:300] !interrupt_oe_n)
    else $error("No interrupt after power-up");
  AST_LOW_POWER: assert property (low_pwr_s |=> !high_power_enable)
    else $error("High power while low power selected");
  AST_PRESENT: assert property (!module_present_n && !module_present_oe_n)
    else $error("Presence line not grounded");
  AST_INT_FOLLOWS: assert property (##1 (interrupt_oe_n == !$past(|flags_reg)))
    else $error("Interrupt does not follow flags");
  AST_OPEN_COLLECTOR: assert property (!interrupt_n && !sda_out && scl_oe_n)
    else $error("Open-drain pin driven high");
  AST_SHORT_PULSE: assert property (mode_ready && !rst_s && (rst_cnt_reg < omsc_pkg::RESET_MIN_CNT)
    |=> mode_ready && (flags_reg[omsc_pkg::FLAG_DONE_BIT] || !$past(flags_reg[omsc_pkg::FLAG_DONE_BIT])
    || $past(flag_clear)))
    else $error("Short reset pulse disturbed module");

endmodule : omsc_top

`default_nettype wire

// File: verilog/omsc_pkg.sv
// Constants, types and helpers for the optical module sideband control block
`default_nettype none

package omsc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_MIN_NS  = 10000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCNT_W        = 12;
  localparam logic [RCNT_W-1:0] RESET_MIN_CNT = RCNT_W'(RESET_MIN_CYC);
  localparam logic [RCNT_W-1:0] RCNT_ZERO     = 12'h000;
  localparam logic [RCNT_W-1:0] RCNT_ONE      = 12'h001;

  // ----------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int FLAG_W = 2;
  localparam logic [6:0]        DEV_ADDR    = 7'h50;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h02;
  localparam logic [ADDR_W-1:0] FLAG_ADDR   = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_ZERO   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ONE    = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_LAST   = 8'hFF;
  localparam logic [DATA_W-1:0] MEM_DEFAULT = 8'h00;
  localparam int DNR_BIT        = 0;
  localparam int FLAG_DONE_BIT  = 0;
  localparam int FLAG_FAULT_BIT = 1;
  localparam logic [FLAG_W-1:0] FLAGS_CLEAR = 2'h0;

  // ----------------------------------------------------------------
  // Two-wire framing and pin sampling
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_ZERO      = 4'h0;
  localparam logic [3:0] BIT_ONE       = 4'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_W   = 5;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_SEL = 2;
  localparam int SYNC_RST = 3;
  localparam int SYNC_LP  = 4;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 5'h1F;

  typedef enum logic [1:0] {OMSC_INIT, OMSC_READY, OMSC_HOLD} omsc_mode_t;

  typedef enum logic [3:0] {
    OMSC_L_IDLE, OMSC_L_ADDR, OMSC_L_ADDR_ACK, OMSC_L_PTR, OMSC_L_PTR_ACK,
    OMSC_L_WDATA, OMSC_L_WDATA_ACK, OMSC_L_RDATA, OMSC_L_RDATA_ACK
  } omsc_link_t;

  // Live bytes are built from logic, not held in the memory
  function automatic logic omsc_is_live(input logic [ADDR_W-1:0] a);
    omsc_is_live = (a == STATUS_ADDR) || (a == FLAG_ADDR);
  endfunction : omsc_is_live

endpackage : omsc_pkg

`default_nettype wire

// File: verilog/omsc_mem.sv
// Management memory map storage with registered read data
`default_nettype none

module omsc_mem (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // Write port
  input  wire logic                       we,
  input  wire logic [omsc_pkg::ADDR_W-1:0] waddr,
  input  wire logic [omsc_pkg::DATA_W-1:0] wdata,
  // Read port
  input  wire logic [omsc_pkg::ADDR_W-1:0] raddr,
  output logic      [omsc_pkg::DATA_W-1:0] rdata
);

  logic [omsc_pkg::DATA_W-1:0] mem_array [0:(1 << omsc_pkg::ADDR_W) - 1];
  logic [omsc_pkg::DATA_W-1:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (we) begin
      mem_array[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= omsc_pkg::MEM_DEFAULT;
    end else begin
      rdata_reg <= mem_array[raddr];
    end
  end

  assign rdata = rdata_reg;

endmodule : omsc_mem

`default_nettype wire

// File: bench/omsc_host.sv
// Host board controller model: two-wire master, pull-ups on the shared lines
`default_nettype none

module omsc_host (
  // Clock
  input  wire logic clk,
  // Module pin drivers
  input  wire logic scl_out,
  input  wire logic scl_oe_n,
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  input  wire logic present_out,
  input  wire logic present_oe_n,
  input  wire logic int_out,
  input  wire logic int_oe_n,
  // Resolved wire levels
  output logic      scl,
  output logic      sda,
  output logic      present_pin,
  output logic      int_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic scl_reg = 1'b1;
  logic sda_reg = 1'b1;

  // ----------------------------------------------------------------
  // Wired-AND lines with host pull-ups
  // ----------------------------------------------------------------
  assign scl         = scl_reg & (scl_oe_n | scl_out);
  assign sda         = sda_reg & (sda_oe_n | sda_out);
  assign present_pin = present_oe_n | present_out;
  assign int_pin     = int_oe_n | int_out;

  // ----------------------------------------------------------------
  // Bit level: 4 clk low, 4 clk high, data moved mid-low
  // ----------------------------------------------------------------
  task automatic bit1(input logic b, output logic r);
    repeat (2) @(negedge clk);
    sda_reg = b;
    repeat (2) @(negedge clk);
    scl_reg = 1'b1;
    repeat (2) @(negedge clk);
    r = sda;
    repeat (2) @(negedge clk);
    scl_reg = 1'b0;
  endtask : bit1

  // Also serves as repeated start from a low clock
  task automatic start();
    repeat (2) @(negedge clk);
    sda_reg = 1'b1;
    repeat (2) @(negedge clk);
    scl_reg = 1'b1;
    repeat (4) @(negedge clk);
    sda_reg = 1'b0;
    repeat (4) @(negedge clk);
    scl_reg = 1'b0;
  endtask : start

  task automatic stop();
    repeat (2) @(negedge clk);
    sda_reg = 1'b0;
    repeat (2) @(negedge clk);
    scl_reg = 1'b1;
    repeat (4) @(negedge clk);
    sda_reg = 1'b1;
    repeat (4) @(negedge clk);
  endtask : stop

  // Last is the ninth bit sent: 1 releases for the module's ACK, or NACKs a read
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit1(d[i], q[i]);
    bit1(last, a);
    ack = ~a;
  endtask : xfer
endmodule : omsc_host

`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the optical module sideband control block
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic module_select_n = 1'b0;
  logic module_reset_n = 1'b1;
  logic low_power_select = 1'b0;
  logic fault_event = 1'b0;
  logic scl, sda, sda_out, sda_oe_n, present_out, present_oe_n, int_out, int_oe_n;
  logic scl_out, scl_oe_n, present_pin, int_pin, high_power_enable, data_not_ready;
  logic [7:0] q;
  logic k;
  int err_count = 0;
  int compares = 0;

  always #4 clk = ~clk;

  omsc_top u_omsc_top (.clk(clk), .reset(reset), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .low_power_select(low_power_select), .scl_in(scl),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .module_present_n(present_out), .module_present_oe_n(present_oe_n), .interrupt_n(int_out),
    .interrupt_oe_n(int_oe_n), .fault_event(fault_event), .high_power_enable(high_power_enable),
    .data_not_ready(data_not_ready));

  omsc_host u_omsc_host (.clk(clk), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .present_out(present_out), .present_oe_n(present_oe_n), .int_out(int_out),
    .int_oe_n(int_oe_n), .scl(scl), .sda(sda), .present_pin(present_pin), .int_pin(int_pin));

  // ----------------------------------------------------------------
  // Transfers and helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic k);
    logic [7:0] x;
    logic k1, k2, k3;
    u_omsc_host.start();
    u_omsc_host.xfer({omsc_pkg::DEV_ADDR, 1'b0}, 1'b1, x, k1);
    u_omsc_host.xfer(a, 1'b1, x, k2);
    u_omsc_host.xfer(d, 1'b1, x, k3);
    u_omsc_host.stop();
    k = k1 & k2 & k3;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic k);
    logic [7:0] x;
    logic k1, k2, k3, k4;
    u_omsc_host.start();
    u_omsc_host.xfer({omsc_pkg::DEV_ADDR, 1'b0}, 1'b1, x, k1);
    u_omsc_host.xfer(a, 1'b1, x, k2);
    u_omsc_host.start();
    u_omsc_host.xfer({omsc_pkg::DEV_ADDR, 1'b1}, 1'b1, x, k3);
    u_omsc_host.xfer(8'hFF, 1'b1, q, k4);
    u_omsc_host.stop();
    k = k1 & k2 & k3;
  endtask : rd

  // Status is meaningless until the module reports ready, so poll first
  task automatic wait_ready();
    int n;
    n = 0;
    while (data_not_ready !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (3) @(negedge clk);
    `CHK(data_not_ready, 1'b0)
    `CHK(int_pin, 1'b0)
  endtask : wait_ready

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    repeat (2) @(negedge clk);
    `CHK(data_not_ready, 1'b1)
    `CHK(int_pin, 1'b1)
    repeat (2) @(negedge clk);
    reset = 1'b0;
    wait_ready();
    `CHK(present_pin, 1'b0)
    rd(8'h02, q, k);
    `CHK(q, 8'h00)
    rd(8'h03, q, k);
    `CHK(q, 8'h01)
    `CHK(int_pin, 1'b1)
  endtask : t_power_up

  task automatic t_rw();
    logic [7:0] x;
    wr(8'h10, 8'h5A, k);
    `CHK(k, 1'b1)
    rd(8'h10, q, k);
    `CHK({k, q}, 9'h15A)
    u_omsc_host.start();
    u_omsc_host.xfer({omsc_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, x, k);
    u_omsc_host.stop();
    `CHK(k, 1'b0)
  endtask : t_rw

  // Multi-byte write and read: pointer steps per byte, master ACK keeps the read going
  task automatic t_burst();
    logic [7:0] x, b0, b1, b2;
    logic ka, k1, k2, k3;
    u_omsc_host.start();
    u_omsc_host.xfer({omsc_pkg::DEV_ADDR, 1'b0}, 1'b1, x, ka);
    u_omsc_host.xfer(8'h11, 1'b1, x, k1);
    u_omsc_host.xfer(8'hC3, 1'b1, x, k2);
    u_omsc_host.xfer(8'h96, 1'b1, x, k3);
    u_omsc_host.stop();
    `CHK({ka, k1, k2, k3}, 4'hF)
    u_omsc_host.start();
    u_omsc_host.xfer({omsc_pkg::DEV_ADDR, 1'b0}, 1'b1, x, ka);
    u_omsc_host.xfer(8'h10, 1'b1, x, k1);
    u_omsc_host.start();
    u_omsc_host.xfer({omsc_pkg::DEV_ADDR, 1'b1}, 1'b1, x, k2);
    u_omsc_host.xfer(8'hFF, 1'b0, b0, k3);
    u_omsc_host.xfer(8'hFF, 1'b0, b1, k3);
    u_omsc_host.xfer(8'hFF, 1'b1, b2, k3);
    u_omsc_host.stop();
    `CHK({b0, b1, b2}, 24'h5AC396)
  endtask : t_burst

  task automatic t_select();
    module_select_n = 1'b1;
    wr(8'h10, 8'hA5, k);
    `CHK(k, 1'b0)
    module_select_n = 1'b0;
    rd(8'h10, q, k);
    `CHK(q, 8'h5A)
  endtask : t_select

  task automatic t_short_reset();
    module_reset_n = 1'b0;
    repeat (1000) @(negedge clk);
    module_reset_n = 1'b1;
    repeat (10) @(negedge clk);
    `CHK(data_not_ready, 1'b0)
    `CHK(int_pin, 1'b1)
    rd(8'h10, q, k);
    `CHK(q, 8'h5A)
  endtask : t_short_reset

  task automatic t_long_reset();
    module_reset_n = 1'b0;
    repeat (1300) @(negedge clk);
    `CHK(data_not_ready, 1'b1)
    module_reset_n = 1'b1;
    wait_ready();
    rd(8'h10, q, k);
    `CHK(q, 8'h00)
    rd(8'h03, q, k);
    `CHK(q, 8'h01)
  endtask : t_long_reset

  task automatic t_low_power();
    low_power_select = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(high_power_enable, 1'b0)
    low_power_select = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(high_power_enable, 1'b1)
  endtask : t_low_power

  task automatic t_fault();
    `CHK(int_pin, 1'b1)
    fault_event = 1'b1;
    @(negedge clk);
    fault_event = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(int_pin, 1'b0)
    rd(8'h03, q, k);
    `CHK(q, 8'h02)
    `CHK(int_pin, 1'b1)
  endtask : t_fault

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d of %0d compares", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    t_power_up();
    t_rw();
    t_burst();
    t_select();
    t_short_reset();
    t_low_power();
    t_fault();
    t_long_reset();
    results();
  end

  // Tests need about 7k cycles; allow ample margin
  initial begin
    #400000;
    err_count++;
    results();
  end
endmodule : tb_top

`default_nettype wire
